// ### core/hpm_regs.svh
// register offsets, field positions, reset values and timing counts of the host port front end
//
// Functional notes
// - chip mode strap high selects host control
// - two bus straps pick one of four modes
// - multiplex strap picks shared or split addressing
// - style strap picks the control signal set
// - multiplexed mode adds an internal chip select
// - cycles finish in fixed time at slow rates
// - ready output stretches cycles for fast hosts
// - each unmasked alarm activation raises interrupt once
// - reading alarm status drops the interrupt
// - per alarm masks gate the interrupt
// - rate strap low means 16x reference clock
`ifndef HPM_REGS_SVH
`define HPM_REGS_SVH

// register byte offsets on the bus
`define OFS_MODE        8'h00
`define OFS_ALARM_STAT  8'h04
`define OFS_ALARM_MASK  8'h08
`define OFS_CHIP_SEL    8'h0C
`define BANK_TAG        2'h1
`define BANK_WORDS      16

// mode register field positions
`define MB_CHIP         0
`define MB_MUX          1
`define MB_STYLE        2
`define MB_RATE         3
`define MB_STD          4
`define MB_CS           5

// alarm layout and reset values
`define ALARM_W         8
`define MASK_RST        8'h00
`define CS_SEL_RST      2'h0

// cycle timing: least access time rounds up to whole cycles
`define CLK_NS          4
`define ACCESS_NS       8
`define ACCESS_CYC      ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CNT_W       3

// reference clock divide for the 16x rate
`define TXDIV_LAST      4'hF

`endif

// ### core/hpm_pkg.sv
// types of the host port front end
`include "hpm_regs.svh"
package hpm_pkg;

  // bus cycle sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_ACK  = 2'b10
  } bus_state_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avm_req_t;

  // strap pins
  typedef struct packed {
    logic       chip_mode_strap;
    logic       bus_multiplex_strap;
    logic       bus_style_strap;
    logic       tx_clock_rate_select;
    logic       tx_clock_standard_select;
    logic [1:0] device_id_strap;
  } strap_t;

  // storage bank state
  typedef struct packed {
    logic [`BANK_WORDS-1:0][7:0] mem;
    logic [7:0]                  rdata;
  } bank_state_t;

  // whole state of the front end
  typedef struct packed {
    bus_state_t              st;
    logic [`ACC_CNT_W-1:0]   wcnt;
    logic [31:0]             rdata;
    logic                    waitreq;
    logic                    wait_out;
    strap_t                  strap_s1;
    strap_t                  strap_s2;
    logic                    ref_s1;
    logic                    ref_s2;
    logic                    ref_d;
    logic [3:0]              txdiv;
    logic                    tx_en;
    logic [`ALARM_W-1:0]     alarm_d;
    logic [`ALARM_W-1:0]     alarm_stat;
    logic [`ALARM_W-1:0]     alarm_mask;
    logic [1:0]              cs_sel;
    logic                    irq;
    logic [1:0]              mode_sel;
  } hpm_state_t;

endpackage : hpm_pkg

// ### core/reg_bank.sv
// sixteen byte storage bank with registered read data
`timescale 1ns/1ps
`default_nettype none
module reg_bank (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // write port
  input  wire logic       we,
  input  wire logic [3:0] waddr,
  input  wire logic [7:0] wdata,
  // read port
  input  wire logic [3:0] raddr,
  output logic      [7:0] rdata
);
  import hpm_pkg::*;

  bank_state_t s;       // current contents
  bank_state_t next_s;  // next contents

  // write one entry, read the addressed one every cycle
  always_comb begin
    next_s = s;
    next_s.rdata = s.mem[raddr];
    if (we) begin
      next_s.mem[waddr] = wdata;
    end
  end

  // register the bank
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // read data straight from its flop
  assign rdata = s.rdata;

endmodule : reg_bank
`default_nettype wire

// ### core/host_port_ctrl.sv
// host port front end: strap modes, register bus slave, alarm interrupt, transmit clock rate
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "hpm_regs.svh"
module host_port_ctrl (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  // register bus
  input  wire hpm_pkg::avm_req_t   avs_req,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest,
  // strap pins
  input  wire hpm_pkg::strap_t     strap_pins,
  // alarm levels from the line channels
  input  wire logic [`ALARM_W-1:0] alarm_in,
  // transmit reference clock pin and its rate enable
  input  wire logic                tx_reference_clock,
  output logic                     tx_clock_enable,
  // decoded configuration
  output logic                     host_mode,
  output logic [1:0]               bus_mode_sel,
  output logic                     addr_shared,
  output logic                     ctrl_style,
  output logic                     tx_clock_is_16x,
  output logic                     tx_clock_is_e1,
  output logic                     chip_select_on,
  // wait-state handshake and interrupt
  output logic                     wait_handshake_out,
  output logic                     alarm_irq
);
  import hpm_pkg::*;

  localparam int WAIT_MAX = `ACCESS_CYC + 1;  // longest wait for an answer

  hpm_state_t          s;         // current state
  hpm_state_t          next_s;    // next state
  logic [`ALARM_W-1:0] rise;      // alarm activations this cycle
  logic                bank_hit;  // request targets the storage bank
  logic                cs_ok;     // internal chip select passes
  logic                csr_ok;    // registers writable
  logic                mem_we;    // bank write strobe
  logic [7:0]          mem_rdata; // bank read data
  logic                req_any;   // any request present

  // one edge detector per alarm line
  genvar gi;
  generate
    for (gi = 0; gi < `ALARM_W; gi = gi + 1) begin : g_rise
      assign rise[gi] = alarm_in[gi] & ~s.alarm_d[gi];
    end
  endgenerate

  // request decode
  assign req_any  = avs_req.read | avs_req.write;
  assign bank_hit = (avs_req.address[7:6] == `BANK_TAG);
  // shared bus mode compares the selected device with the own id strap
  assign cs_ok    = ~s.strap_s2.bus_multiplex_strap
                  | (s.cs_sel == s.strap_s2.device_id_strap);
  // direct logic mode locks software out
  assign csr_ok   = s.strap_s2.chip_mode_strap;
  // bank write lands at the accepting edge only
  assign mem_we   = (s.st == ST_ACK) & avs_req.write & avs_req.byteenable[0]
                  & bank_hit & csr_ok & cs_ok;

  // storage bank of sixteen locations behind the host port
  reg_bank u_bank (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (mem_we),
    .waddr   (avs_req.address[5:2]),
    .wdata   (avs_req.writedata[7:0]),
    .raddr   (avs_req.address[5:2]),
    .rdata   (mem_rdata)
  );

  // next state of the whole front end
  always_comb begin
    next_s = s;

    // strap and reference clock synchronisers
    next_s.strap_s1 = strap_pins;
    next_s.strap_s2 = s.strap_s1;
    next_s.ref_s1   = tx_reference_clock;
    next_s.ref_s2   = s.ref_s1;
    next_s.ref_d    = s.ref_s2;

    // four interface modes from the two bus straps
    next_s.mode_sel = {s.strap_s2.bus_multiplex_strap, s.strap_s2.bus_style_strap};

    // transmit rate enable: every edge, or every sixteenth edge
    next_s.tx_en = 1'b0;
    if (s.strap_s2.tx_clock_rate_select) begin
      // primary rate clock
      next_s.txdiv = 4'h0;
      next_s.tx_en = s.ref_s2 & ~s.ref_d;
    end else if (s.ref_s2 & ~s.ref_d) begin
      // 16x clock, count edges
      next_s.txdiv = s.txdiv + 4'h1;
      next_s.tx_en = (s.txdiv == `TXDIV_LAST);
    end

    // alarm history for edge detection
    next_s.alarm_d = alarm_in;

    // bus cycle sequencer
    next_s.waitreq  = 1'b1;
    next_s.wait_out = 1'b0;
    case (s.st)
      ST_IDLE: begin
        // take a new request and stretch the cycle
        if (req_any) begin
          next_s.st       = ST_BUSY;
          next_s.wcnt     = `ACC_CNT_W'(`ACCESS_CYC - 1);
          next_s.wait_out = 1'b1;
        end
      end
      ST_BUSY: begin
        if (s.wcnt == '0) begin
          // answer next cycle, data ready now
          next_s.st      = ST_ACK;
          next_s.waitreq = 1'b0;
          next_s.rdata   = 32'h00000000;
          if (avs_req.read) begin
            if (bank_hit) begin
              // bank reads blocked by chip select return zero
              if (csr_ok && cs_ok) begin
                next_s.rdata = {24'h000000, mem_rdata};
              end
            end else if (avs_req.address == `OFS_MODE) begin
              // strap view, always readable
              next_s.rdata[`MB_CHIP]  = s.strap_s2.chip_mode_strap;
              next_s.rdata[`MB_MUX]   = s.strap_s2.bus_multiplex_strap;
              next_s.rdata[`MB_STYLE] = s.strap_s2.bus_style_strap;
              next_s.rdata[`MB_RATE]  = s.strap_s2.tx_clock_rate_select;
              next_s.rdata[`MB_STD]   = s.strap_s2.tx_clock_standard_select;
              next_s.rdata[`MB_CS]    = ~cs_ok;
            end else if (!csr_ok) begin
              // direct logic mode hides the rest
              next_s.rdata = 32'h00000000;
            end else if (avs_req.address == `OFS_ALARM_STAT) begin
              next_s.rdata = {24'h000000, s.alarm_stat};
            end else if (avs_req.address == `OFS_ALARM_MASK) begin
              next_s.rdata = {24'h000000, s.alarm_mask};
            end else if (avs_req.address == `OFS_CHIP_SEL) begin
              next_s.rdata = {26'h0, s.strap_s2.device_id_strap, 2'h0, s.cs_sel};
            end else begin
              // unmapped: zero, no effect
              next_s.rdata = 32'h00000000;
            end
          end
        end else begin
          // keep stretching
          next_s.wcnt     = s.wcnt - `ACC_CNT_W'(1);
          next_s.wait_out = 1'b1;
        end
      end
      ST_ACK: begin
        // the request is accepted at this edge
        next_s.st = ST_IDLE;
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // register writes at the accepting edge, lane zero only
    if (s.st == ST_ACK && avs_req.write && avs_req.byteenable[0] && csr_ok) begin
      if (avs_req.address == `OFS_ALARM_MASK) begin
        next_s.alarm_mask = avs_req.writedata[`ALARM_W-1:0];
      end else if (avs_req.address == `OFS_CHIP_SEL) begin
        next_s.cs_sel = avs_req.writedata[1:0];
      end else if (avs_req.address == `OFS_ALARM_STAT) begin
        // write one to clear
        next_s.alarm_stat = s.alarm_stat & ~avs_req.writedata[`ALARM_W-1:0];
      end
    end

    // reading the status clears every sticky bit
    if (s.st == ST_ACK && avs_req.read && csr_ok && avs_req.address == `OFS_ALARM_STAT) begin
      next_s.alarm_stat = 8'h00;
    end

    // new activations win over any clear
    next_s.alarm_stat = next_s.alarm_stat | rise;

    // level interrupt from unmasked sticky bits, host mode only
    next_s.irq = csr_ok & (|(s.alarm_stat & s.alarm_mask));
  end

  // register the whole state
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      s            <= '0;
      s.st         <= ST_IDLE;
      s.waitreq    <= 1'b1;
      s.alarm_mask <= `MASK_RST;
      s.cs_sel     <= `CS_SEL_RST;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flops
  assign avs_readdata       = s.rdata;
  assign avs_waitrequest    = s.waitreq;
  assign wait_handshake_out = s.wait_out;
  assign alarm_irq          = s.irq;
  assign tx_clock_enable    = s.tx_en;
  assign bus_mode_sel       = s.mode_sel;
  assign host_mode          = s.strap_s2.chip_mode_strap;
  assign addr_shared        = s.strap_s2.bus_multiplex_strap;
  assign ctrl_style         = s.strap_s2.bus_style_strap;
  assign tx_clock_is_16x    = ~s.strap_s2.tx_clock_rate_select;
  assign tx_clock_is_e1     = s.strap_s2.tx_clock_standard_select;
  assign chip_select_on     = s.strap_s2.bus_multiplex_strap;

  // every request is answered within the stretch time
  property p_wait_bounded;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_IDLE && req_any) |-> ##[1:WAIT_MAX] !avs_waitrequest;
  endproperty
  a_wait_bounded: assert property (p_wait_bounded) else $error("request not answered in time");

  // the answer lasts one cycle
  property p_ack_single;
    @(posedge clk_sys) disable iff (!rstn)
      !avs_waitrequest |=> avs_waitrequest && !wait_handshake_out;
  endproperty
  a_ack_single: assert property (p_ack_single) else $error("answer longer than one cycle");

  // interrupt only from an unmasked set bit
  property p_irq_cause;
    @(posedge clk_sys) disable iff (!rstn)
      alarm_irq |-> $past(|(s.alarm_stat & s.alarm_mask));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without unmasked alarm");

  // a status read leaves only fresh activations
  property p_read_clears;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_ACK && avs_req.read && csr_ok && avs_req.address == `OFS_ALARM_STAT)
      |=> ((s.alarm_stat & ~$past(rise)) == 8'h00);
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("status not cleared by read");

  // every activation is caught
  property p_alarm_caught;
    @(posedge clk_sys) disable iff (!rstn)
      (|rise) |=> ((s.alarm_stat & $past(rise)) == $past(rise));
  endproperty
  a_alarm_caught: assert property (p_alarm_caught) else $error("alarm activation lost");

  // the mode follows both bus straps one cycle on
  property p_mode_decode;
    @(posedge clk_sys) disable iff (!rstn)
      ##2 bus_mode_sel == $past({addr_shared, ctrl_style});
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("bus mode not decoded from straps");

  // direct logic mode keeps the interrupt low
  property p_direct_quiet;
    @(posedge clk_sys) disable iff (!rstn)
      !host_mode |=> !alarm_irq;
  endproperty
  a_direct_quiet: assert property (p_direct_quiet) else $error("interrupt in direct logic mode");

  // chip select mismatch blocks bank writes
  property p_cs_blocks;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_ACK && avs_req.write && bank_hit && addr_shared
       && s.cs_sel != s.strap_s2.device_id_strap) |-> !mem_we;
  endproperty
  a_cs_blocks: assert property (p_cs_blocks) else $error("bank written while deselected");

  // the 16x rate enable is spaced by many cycles
  property p_tx_div;
    @(posedge clk_sys) disable iff (!rstn)
      (tx_clock_enable && tx_clock_is_16x && $past(tx_clock_is_16x, 3)) |=> !tx_clock_enable [*8];
  endproperty
  a_tx_div: assert property (p_tx_div) else $error("16x enable too frequent");

  // unmapped reads answer zero
  property p_unmapped_zero;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_ACK && avs_req.read && !bank_hit && avs_req.address > `OFS_CHIP_SEL)
      |-> avs_readdata == 32'h00000000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

  // the stretch covers two cycles, then the answer comes
  property p_stretch_count;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_IDLE && req_any) |=> wait_handshake_out [*2] ##1 (!wait_handshake_out && !avs_waitrequest);
  endproperty
  a_stretch_count: assert property (p_stretch_count) else $error("stretch length wrong");

  // the handshake output is high only inside a stretched cycle
  property p_wait_out_busy;
    @(posedge clk_sys) disable iff (!rstn)
      wait_handshake_out |-> (avs_waitrequest && s.st == ST_BUSY);
  endproperty
  a_wait_out_busy: assert property (p_wait_out_busy) else $error("handshake outside a stretch");

  // nothing is answered while the sequencer idles
  property p_ready_idle;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_IDLE) |-> avs_waitrequest;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("answer while idle");

  // in host mode any unmasked sticky bit raises the interrupt one cycle on
  property p_irq_from_status;
    @(posedge clk_sys) disable iff (!rstn)
      (host_mode && (|(s.alarm_stat & s.alarm_mask))) |=> alarm_irq;
  endproperty
  a_irq_from_status: assert property (p_irq_from_status) else $error("unmasked alarm without interrupt");

  // with every alarm masked the interrupt stays low
  property p_mask_blocks;
    @(posedge clk_sys) disable iff (!rstn)
      (s.alarm_mask == 8'h00) |=> !alarm_irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) else $error("interrupt while all masked");

  // a status read with no fresh activation drops the interrupt two cycles on
  property p_irq_drop;
    @(posedge clk_sys) disable iff (!rstn)
      (s.st == ST_ACK && avs_req.read && csr_ok && avs_req.address == `OFS_ALARM_STAT && !(|rise))
      |=> ##1 !alarm_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt kept after status read");

  // direct logic mode leaves the masks and the selection untouched
  property p_direct_locked;
    @(posedge clk_sys) disable iff (!rstn)
      !csr_ok |=> ($stable(s.alarm_mask) && $stable(s.cs_sel));
  endproperty
  a_direct_locked: assert property (p_direct_locked) else $error("register changed in direct mode");

  // at line rate every synchronised rise gives one enable
  property p_tx_line_rate;
    @(posedge clk_sys) disable iff (!rstn)
      (!tx_clock_is_16x && s.ref_s2 && !s.ref_d) |=> tx_clock_enable;
  endproperty
  a_tx_line_rate: assert property (p_tx_line_rate) else $error("line rate enable missing");

endmodule : host_port_ctrl
`default_nettype wire

// ### tb/host_master.sv
// host bus master model that honours the slave's wait-states
`timescale 1ns/1ps
`default_nettype none
module host_master (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rstn,
  // command from the bench
  input  wire logic          go,
  input  wire logic          cmd_wr,
  input  wire logic [7:0]    cmd_addr,
  input  wire logic [31:0]   cmd_data,
  input  wire logic [3:0]    cmd_be,
  // register bus
  output hpm_pkg::avm_req_t  req,
  input  wire logic          waitreq,
  input  wire logic [31:0]   rdata_in,
  input  wire logic          stretch,
  // result of the finished cycle
  output logic               done,
  output logic [31:0]        rdata,
  output logic [3:0]         lat,
  output logic [3:0]         nstr
);
  import hpm_pkg::*;
  logic [3:0] cnt;   // cycles since the request rose
  logic [3:0] scnt;  // stretched cycles seen so far
  // request held until waitrequest is sampled low, then released
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req   <= '0;
      done  <= 1'b0;
      rdata <= '0;
      lat   <= '0;
      nstr  <= '0;
      cnt   <= '0;
      scnt  <= '0;
    end else begin
      done <= 1'b0;
      if (req.read || req.write) begin
        if (waitreq) begin
          cnt  <= cnt + 4'h1;
          scnt <= scnt + {3'h0, stretch};
        end else begin
          // take the answer at the accepting edge only
          rdata           <= rdata_in;
          lat             <= cnt;
          nstr            <= scnt + {3'h0, stretch};
          done            <= 1'b1;
          req.read        <= 1'b0;
          req.write       <= 1'b0;
          req.address     <= ~req.address;
          req.writedata   <= ~req.writedata;
        end
      end else if (go) begin
        req.read       <= !cmd_wr;
        req.write      <= cmd_wr;
        req.address    <= cmd_addr;
        req.writedata  <= cmd_data;
        req.byteenable <= cmd_be;
        cnt            <= '0;
        scnt           <= '0;
      end
    end
  end
endmodule : host_master
`default_nettype wire

// ### tb/tb.sv
// self-checking bench of the host port front end
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hpm_pkg::*;
  logic        clk_sys, rstn, go, cmd_wr, done, ref_clk, tx_en, host_mode;
  logic        addr_shared, ctrl_style, is16, ise1, cs_on, whs, irq, waitreq;
  logic [1:0]  bms;
  logic [7:0]  cmd_addr, alarm_in;
  logic [31:0] cmd_data, rd, avs_rd, v, d;
  logic [3:0]  lat, nstr, cmd_be;
  avm_req_t    req;
  strap_t      straps;
  logic [32:0] expq[$]; // bit 32 set when read data is compared
  logic [32:0] e;
  int          bad_count, check_count, npulse, i;

  // clock at 250 MHz
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  host_port_ctrl u_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_req(req), .avs_readdata(avs_rd),
    .avs_waitrequest(waitreq), .strap_pins(straps), .alarm_in(alarm_in), .tx_reference_clock(ref_clk),
    .tx_clock_enable(tx_en), .host_mode(host_mode), .bus_mode_sel(bms), .addr_shared(addr_shared),
    .ctrl_style(ctrl_style), .tx_clock_is_16x(is16), .tx_clock_is_e1(ise1), .chip_select_on(cs_on),
    .wait_handshake_out(whs), .alarm_irq(irq));

  host_master u_host (.clk_sys(clk_sys), .rstn(rstn), .go(go), .cmd_wr(cmd_wr), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .cmd_be(cmd_be), .req(req), .waitreq(waitreq), .rdata_in(avs_rd), .stretch(whs),
    .done(done), .rdata(rd), .lat(lat), .nstr(nstr));

  // compare one value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // verdict and end of run
  task automatic close_out();
    // notes left over mean answers went missing
    if (expq.size() != 0) bad_count++;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // wait k settled points
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask : cyc

  // one bus cycle through the host model, expectation noted first
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [32:0] x);
    int n;
    expq.push_back(x);
    @(posedge clk_sys);
    go       <= 1'b1;
    cmd_wr   <= wr;
    cmd_addr <= a;
    cmd_data <= wd;
    @(posedge clk_sys);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= 50) begin
      bad_count++;
      close_out();
    end
  endtask : bus

  // reference clock rises, each high and low several system cycles
  task automatic rises(input int k);
    repeat (k) begin
      @(posedge clk_sys);
      ref_clk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      ref_clk <= 1'b0;
      repeat (2) @(posedge clk_sys);
    end
    cyc(8);
  endtask : rises

  // watcher: each finished cycle is matched against the oldest note
  always @(negedge clk_sys) begin
    if (done === 1'b1 && expq.size() > 0) begin
      e = expq.pop_front();
      check(32'(lat), 32'h3);
      check(32'(nstr), 32'h2);
      if (e[32]) check(rd, e[31:0]);
    end else if (done === 1'b1) begin
      // an answer that nobody asked for
      bad_count++;
    end
    if (tx_en === 1'b1) npulse++;
  end

  initial begin
    rstn = 1'b0; go = 1'b0; cmd_wr = 1'b0; cmd_addr = '0; cmd_data = '0;
    alarm_in = '0; ref_clk = 1'b0; straps = strap_t'(7'h5A);
    cmd_be = 4'hF;
    bad_count = 0; check_count = 0; npulse = 0;
    void'($urandom(32'h2605ed25));
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    cyc(4);
    // strap decode and mode register, random straps then a fixed setting
    for (i = 0; i < 9; i++) begin
      v = $urandom;
      @(posedge clk_sys);
      straps <= (i == 8) ? strap_t'(7'h5A) : strap_t'(v[6:0]);
      cyc(5);
      check(32'(host_mode), 32'(straps.chip_mode_strap));
      check(32'(bms), 32'({straps.bus_multiplex_strap, straps.bus_style_strap}));
      check(32'(addr_shared), 32'(straps.bus_multiplex_strap));
      check(32'(ctrl_style), 32'(straps.bus_style_strap));
      check(32'(cs_on), 32'(straps.bus_multiplex_strap));
      check(32'(is16), 32'(!straps.tx_clock_rate_select));
      check(32'(ise1), 32'(straps.tx_clock_standard_select));
      v = {26'h0, straps.bus_multiplex_strap && straps.device_id_strap != 2'h0,
           straps.tx_clock_standard_select, straps.tx_clock_rate_select,
           straps.bus_style_strap, straps.bus_multiplex_strap, straps.chip_mode_strap};
      bus(1'b0, 8'h00, '0, {1'b1, v});
    end
    $display("test straps done");
    // masks, one interrupt per activation, clear by read and by write one
    bus(1'b1, 8'h08, 32'h1, '0);
    bus(1'b0, 8'h08, '0, {1'b1, 32'h1});
    @(posedge clk_sys) alarm_in <= 8'h02;
    cyc(4);
    check(32'(irq), 32'h0);
    @(posedge clk_sys) alarm_in <= 8'h03;
    cyc(3);
    check(32'(irq), 32'h1);
    bus(1'b0, 8'h04, '0, {1'b1, 32'h3});
    cyc(1);
    check(32'(irq), 32'h0);
    bus(1'b0, 8'h04, '0, {1'b1, 32'h0});
    check(32'(irq), 32'h0);
    @(posedge clk_sys) alarm_in <= 8'h00;
    @(posedge clk_sys) alarm_in <= 8'h01;
    cyc(3);
    check(32'(irq), 32'h1);
    bus(1'b1, 8'h04, 32'h1, '0);
    cyc(1);
    check(32'(irq), 32'h0);
    // masked activation found by polling only
    @(posedge clk_sys) alarm_in <= 8'h05;
    cyc(3);
    check(32'(irq), 32'h0);
    bus(1'b0, 8'h04, '0, {1'b1, 32'h4});
    $display("test alarms done");
    // storage bank, internal chip select, unmapped place
    d = {24'h0, 8'($urandom)};
    bus(1'b1, 8'h44, d, '0);
    @(posedge clk_sys) straps <= strap_t'(7'h7A);
    cyc(5);
    bus(1'b0, 8'h44, '0, {1'b1, 32'h0});
    bus(1'b1, 8'h0C, 32'h2, '0);
    bus(1'b0, 8'h0C, '0, {1'b1, 32'h22});
    bus(1'b0, 8'h44, '0, {1'b1, d});
    bus(1'b1, 8'h80, 32'hFF, '0);
    bus(1'b0, 8'h80, '0, {1'b1, 32'h0});
    bus(1'b0, 8'h44, '0, {1'b1, d});
    $display("test chip select done");
    // direct control drops writes and hides registers
    @(posedge clk_sys) straps <= strap_t'(7'h3A);
    cyc(5);
    bus(1'b1, 8'h08, 32'h55, '0);
    bus(1'b0, 8'h08, '0, {1'b1, 32'h0});
    @(posedge clk_sys) straps <= strap_t'(7'h7A);
    cyc(5);
    bus(1'b0, 8'h08, '0, {1'b1, 32'h1});
    // a write without lane zero is answered but dropped
    @(posedge clk_sys) cmd_be <= 4'hE;
    bus(1'b1, 8'h08, 32'hFF, '0);
    @(posedge clk_sys) cmd_be <= 4'hF;
    bus(1'b0, 8'h08, '0, {1'b1, 32'h1});
    $display("test direct mode done");
    // transmit clock rate: every rise at line rate, one per sixteen at 16x
    npulse = 0;
    rises(4);
    check(32'(npulse), 32'h4);
    @(posedge clk_sys) straps <= strap_t'(7'h72);
    cyc(5);
    npulse = 0;
    rises(32);
    check(32'(npulse), 32'h2);
    $display("test transmit clock done");
    close_out();
  end
endmodule : tb
`default_nettype wire
